// ---- rtl/pcsd_pkg.sv ----
package pcsd_pkg;

   // register geometry
   localparam int PCSD_STAGES = 32;
   localparam int PCSD_CNT_W = 6;
   localparam logic [PCSD_STAGES-1:0] PCSD_STAGE_RST = 32'hffff_ffff;
   localparam logic [PCSD_STAGES-1:0] PCSD_OUT_RST = 32'hffff_ffff;
   localparam logic [PCSD_STAGES-1:0] PCSD_ALL_LOW = 32'h0000_0000;
   localparam logic [PCSD_STAGES-1:0] PCSD_ALL_HIGH = 32'hffff_ffff;
   localparam logic [PCSD_CNT_W-1:0] PCSD_CNT_RST = 6'h00;
   localparam logic [PCSD_CNT_W-1:0] PCSD_CNT_FULL = 6'h20;
   localparam logic [PCSD_CNT_W-1:0] PCSD_CNT_ONE = 6'h01;

   // buffering between pin sampling and the stage chain
   localparam int PCSD_FIFO_WIDTH = 1;
   localparam int PCSD_FIFO_DEPTH = 16;

   // pin sampling
   localparam int PCSD_PIN_COUNT = 4;
   localparam logic [PCSD_PIN_COUNT-1:0] PCSD_PIN_RST = 4'he;

   // positions of the pins in the sampled vector
   localparam int PCSD_PIN_SCLK = 0;
   localparam int PCSD_PIN_DATA = 1;
   localparam int PCSD_PIN_GATE = 2;
   localparam int PCSD_PIN_FORCE = 3;

   // drive state of the electrode bank
   typedef enum logic [1:0] {
      PCSD_DRV_REST,
      PCSD_DRV_GATED,
      PCSD_DRV_FORCED
   } pcsd_drive_e;

endpackage

// ---- rtl/pcsd_sync.sv ----
`timescale 1ns/1ps
module pcsd_sync
   import pcsd_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // two-flop synchroniser; only the second flop is read outside
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ---- rtl/pcsd_fifo.sv ----
`timescale 1ns/1ps
module pcsd_fifo
   import pcsd_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   logic push;
   logic pop;

   // full and empty come straight from the occupancy count
   assign wr_ready = (count_q != DEPTH_CNT);
   assign rd_valid = (count_q != '0);
   assign rd_data = mem_q[rd_ptr_q];
   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;

   // storage, written only on an accepted push
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

   // occupancy; a push and pop together leave it unchanged
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
         count_q <= count_q - 1'b1;
      end
   end

endmodule

// ---- rtl/pcsd_driver.sv ----
`timescale 1ns/1ps

module pcsd_driver
   import pcsd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic shift_clk_pin,
   input wire logic serial_in_pin,
   input wire logic gate_n_pin,
   input wire logic force_all_low_n,
   output logic [PCSD_STAGES-1:0] electrode_out,
   output logic serial_cascade_out,
   output logic serial_in_ready,
   output logic frame_loaded,
   output logic shift_overrun,
   output logic [1:0] drive_state
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------

   // rising transition between two consecutive synchronised samples
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur && !prev;
   endfunction

   // falling transition between two consecutive synchronised samples
   function automatic logic fall(input logic cur, input logic prev);
      fall = !cur && prev;
   endfunction

   // one shift step: new bit enters stage one, stage n moves to n+1
   function automatic logic [PCSD_STAGES-1:0] shift_step(
      input logic [PCSD_STAGES-1:0] stages,
      input logic bit_in
   );
      shift_step = {stages[PCSD_STAGES-2:0], bit_in};
   endfunction

   // ------------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------------

   logic [PCSD_PIN_COUNT-1:0] pins_raw;
   logic [PCSD_PIN_COUNT-1:0] pins_sync;
   logic sclk_s;
   logic data_s;
   logic gate_n_s;
   logic force_n_s;

   // all four control pins are asynchronous to clk
   assign pins_raw[PCSD_PIN_SCLK] = shift_clk_pin;
   assign pins_raw[PCSD_PIN_DATA] = serial_in_pin;
   assign pins_raw[PCSD_PIN_GATE] = gate_n_pin;
   assign pins_raw[PCSD_PIN_FORCE] = force_all_low_n;

   pcsd_sync #(
      .WIDTH(PCSD_PIN_COUNT),
      .RST_VAL(PCSD_PIN_RST)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   assign sclk_s = pins_sync[PCSD_PIN_SCLK];
   assign data_s = pins_sync[PCSD_PIN_DATA];
   assign gate_n_s = pins_sync[PCSD_PIN_GATE];
   assign force_n_s = pins_sync[PCSD_PIN_FORCE];

   // ------------------------------------------------------------------
   // edge detection on the synchronised shift clock and gate
   // ------------------------------------------------------------------

   logic sclk_prev_q;
   logic gate_n_prev_q;
   logic sclk_rise;
   logic gate_fall;

   // history flops read only the synchroniser's second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_prev_q <= 1'b0;
         gate_n_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         gate_n_prev_q <= gate_n_s;
      end
   end

   // data is sampled alongside the clock, so setup at the pin carries over
   assign sclk_rise = rise(sclk_s, sclk_prev_q);
   assign gate_fall = fall(gate_n_s, gate_n_prev_q);

   // ------------------------------------------------------------------
   // bit buffer between the pin and the stage chain
   // ------------------------------------------------------------------

   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [PCSD_FIFO_WIDTH-1:0] fifo_rd_data;
   logic shift_now;

   // the chain is frozen while the gate is low, so a pattern being
   // applied never moves; bits clocked in meanwhile wait in the buffer
   assign fifo_rd_ready = gate_n_s;
   assign shift_now = fifo_rd_valid && fifo_rd_ready;

   pcsd_fifo #(
      .WIDTH(PCSD_FIFO_WIDTH),
      .DEPTH(PCSD_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .wr_valid(sclk_rise),
      .wr_ready(fifo_wr_ready),
      .wr_data(data_s),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   // the controller sees the buffer's room; a pin edge cannot be stalled
   assign serial_in_ready = fifo_wr_ready;

   // ------------------------------------------------------------------
   // stage chain
   // ------------------------------------------------------------------

   logic [PCSD_STAGES-1:0] shift_stage_q;

   // gate and force-low never touch the stored content
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_stage_q <= PCSD_STAGE_RST;
      end else if (shift_now) begin
         shift_stage_q <= shift_step(shift_stage_q, fifo_rd_data[0]);
      end
   end

   // cascade output is the last stage flop itself, no extra delay
   assign serial_cascade_out = shift_stage_q[PCSD_STAGES-1];

   // ------------------------------------------------------------------
   // frame bookkeeping
   // ------------------------------------------------------------------

   logic [PCSD_CNT_W-1:0] bit_cnt_q;

   // counts bits moved into the chain since the last gate pulse;
   // saturates so a long chain feed-through still reads as loaded
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_q <= PCSD_CNT_RST;
      end else if (gate_fall) begin
         bit_cnt_q <= PCSD_CNT_RST;
      end else if (shift_now && bit_cnt_q != PCSD_CNT_FULL) begin
         bit_cnt_q <= bit_cnt_q + PCSD_CNT_ONE;
      end
   end

   assign frame_loaded = (bit_cnt_q == PCSD_CNT_FULL);

   // ------------------------------------------------------------------
   // overrun flag
   // ------------------------------------------------------------------

   logic overrun_q;

   // a shift edge that found the buffer full lost its bit; the flag is
   // sticky and cleared by the next gate pulse, a new loss wins the clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overrun_q <= 1'b0;
      end else if (sclk_rise && !fifo_wr_ready) begin
         overrun_q <= 1'b1;
      end else if (gate_fall) begin
         overrun_q <= 1'b0;
      end
   end

   assign shift_overrun = overrun_q;

   // ------------------------------------------------------------------
   // electrode drive
   // ------------------------------------------------------------------

   pcsd_drive_e drive_d;
   pcsd_drive_e drive_q;
   logic [PCSD_STAGES-1:0] electrode_d;
   logic [PCSD_STAGES-1:0] electrode_q;

   // force-low dominates, then the gate, otherwise rest
   always_comb begin
      if (!force_n_s) begin
         drive_d = PCSD_DRV_FORCED;
      end else if (!gate_n_s) begin
         drive_d = PCSD_DRV_GATED;
      end else begin
         drive_d = PCSD_DRV_REST;
      end
   end

   // pattern for each drive state
   always_comb begin
      case (drive_d)
         PCSD_DRV_REST: begin
            electrode_d = PCSD_ALL_HIGH;
         end
         PCSD_DRV_GATED: begin
            // a low stage pulls its electrode low, a high one stays high
            electrode_d = shift_stage_q;
         end
         PCSD_DRV_FORCED: begin
            electrode_d = PCSD_ALL_LOW;
         end
         default: begin
            electrode_d = PCSD_ALL_HIGH;
         end
      endcase
   end

   // registered so the high-voltage stage never sees decode glitches
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         electrode_q <= PCSD_OUT_RST;
         drive_q <= PCSD_DRV_REST;
      end else begin
         electrode_q <= electrode_d;
         drive_q <= drive_d;
      end
   end

   assign electrode_out = electrode_q;
   assign drive_state = drive_q;

endmodule

// ---- verif/pcsd_driver_monitor.sv ----
`timescale 1ns/1ps
module pcsd_driver_monitor
   import pcsd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic shift_clk_pin,
   input wire logic gate_n_pin,
   input wire logic force_all_low_n,
   input wire logic [PCSD_STAGES-1:0] electrode_out,
   input wire logic serial_cascade_out,
   input wire logic [1:0] drive_state
);
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [5:0] quiet_q;

   // pin levels as the three-cycle input path sees them
   sequence rest_s; gate_n_pin && force_all_low_n; endsequence
   sequence gated_s; !gate_n_pin && force_all_low_n; endsequence
   sequence forced_s; !force_all_low_n; endsequence

   // idle cycles with no shift edge; long enough for a full buffer to drain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quiet_q <= 6'h00;
      end else if (!(gate_n_pin && force_all_low_n && !shift_clk_pin)) begin
         quiet_q <= 6'h00;
      end else if (quiet_q != 6'h3f) begin
         quiet_q <= quiet_q + 6'h01;
      end
   end

   rest_high_a: assert property (rest_s [*5] |-> electrode_out == PCSD_ALL_HIGH)
      else $error("electrodes not high at rest");
   rest_state_a: assert property (rest_s [*5] |-> drive_state == 2'h0)
      else $error("drive state not rest");
   force_low_a: assert property (forced_s [*5] |-> electrode_out == PCSD_ALL_LOW && drive_state == 2'h2)
      else $error("electrodes not forced low");
   gated_copy_a: assert property (gated_s [*6] |-> electrode_out[PCSD_STAGES-1] == serial_cascade_out)
      else $error("last electrode differs from cascade");
   gated_hold_a: assert property (gated_s [*7] |-> $stable(electrode_out) && drive_state == 2'h1)
      else $error("gated electrodes moved");
   shift_quiet_a: assert property (quiet_q >= 6'h32 |-> $stable(serial_cascade_out))
      else $error("cascade moved without a shift edge");
endmodule

bind pcsd_driver pcsd_driver_monitor u_mon (
   .clk(clk),
   .rst_b(rst_b),
   .shift_clk_pin(shift_clk_pin),
   .gate_n_pin(gate_n_pin),
   .force_all_low_n(force_all_low_n),
   .electrode_out(electrode_out),
   .serial_cascade_out(serial_cascade_out),
   .drive_state(drive_state)
);

// ---- verif/pcsd_ctrl_model.sv ----
`timescale 1ns/1ps
module pcsd_ctrl_model (
   input wire logic clk,
   output logic shift_clk_pin,
   output logic serial_in_pin,
   output logic gate_n_pin,
   output logic force_all_low_n
);
   // idle pins: shift clock parked low, gate and force released high
   initial begin
      shift_clk_pin = 1'b0;
      serial_in_pin = 1'b0;
      gate_n_pin = 1'b1;
      force_all_low_n = 1'b1;
   end

   // step n edges, then move just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // data leads the rise by two cycles, holds until one cycle past the fall, then is inverted
   task automatic send_bit(input logic b);
      serial_in_pin = b;
      tick(2);
      shift_clk_pin = 1'b1;
      tick(4);
      shift_clk_pin = 1'b0;
      tick(1);
      serial_in_pin = ~b;
      tick(1);
   endtask

   // msb first, so bit n-1 travels furthest down the chain
   task automatic send_word(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) send_bit(w[i]);
   endtask

   // gate and force change together, then settle past the input path
   task automatic set_pins(input logic g, input logic f);
      gate_n_pin = g;
      force_all_low_n = f;
      tick(6);
   endtask
endmodule

// ---- verif/test_plasma_column_shift_driver.sv ----
`timescale 1ns/1ps
module test_plasma_column_shift_driver;
   import pcsd_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sclk, sdat, gate_n, force_n, casc, ready, loaded, overrun;
   logic [PCSD_STAGES-1:0] elec;
   logic [1:0] dstate;
   int miscompares = 0;
   int total_checks = 0;
   logic [31:0] pat = 32'h5a3c_e10f;
   logic [31:0] cur;

   always #20 clk = ~clk;

   pcsd_ctrl_model ctrl (.clk(clk), .shift_clk_pin(sclk), .serial_in_pin(sdat), .gate_n_pin(gate_n),
      .force_all_low_n(force_n));
   pcsd_driver DUT (.clk(clk), .rst_b(rst_b), .shift_clk_pin(sclk), .serial_in_pin(sdat),
      .gate_n_pin(gate_n), .force_all_low_n(force_n), .electrode_out(elec), .serial_cascade_out(casc),
      .serial_in_ready(ready), .frame_loaded(loaded), .shift_overrun(overrun), .drive_state(dstate));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic test_reset();
      check(elec, PCSD_ALL_HIGH, "reset electrodes");
      check({ready, overrun, loaded}, 32'h4, "reset status");
      $display("test_reset finished");
   endtask

   // full frame with gate high, then one gate pulse applies it
   task automatic test_load();
      ctrl.send_word(pat, 32);
      ctrl.tick(8);
      check(elec, PCSD_ALL_HIGH, "loading electrodes");
      check(casc, pat[31], "cascade after frame");
      check(loaded, 32'h1, "frame loaded");
      ctrl.set_pins(1'b0, 1'b1);
      check(elec, pat, "gated pattern");
      check(dstate, 32'h1, "gated state");
      ctrl.set_pins(1'b1, 1'b1);
      check(elec, PCSD_ALL_HIGH, "after gate");
      $display("test_load finished");
   endtask

   task automatic test_shift();
      ctrl.send_word(32'h0, 1);
      ctrl.tick(8);
      cur = {pat[30:0], 1'b0};
      check(casc, pat[30], "cascade after one shift");
      ctrl.set_pins(1'b0, 1'b1);
      check(elec, cur, "shifted pattern");
      ctrl.set_pins(1'b1, 1'b1);
      $display("test_shift finished");
   endtask

   task automatic test_force();
      ctrl.set_pins(1'b1, 1'b0);
      check(elec, PCSD_ALL_LOW, "forced, gate high");
      check(dstate, 32'h2, "forced state");
      ctrl.set_pins(1'b0, 1'b0);
      check(elec, PCSD_ALL_LOW, "forced, gate low");
      ctrl.set_pins(1'b0, 1'b1);
      check(elec, cur, "content kept");
      ctrl.set_pins(1'b1, 1'b1);
      $display("test_force finished");
   endtask

   // 17 bits while gated: 16 fill the buffer, the last is lost, then drain
   task automatic test_overrun();
      int n;
      ctrl.set_pins(1'b0, 1'b1);
      ctrl.send_word(32'h1_a5c3, 17);
      check({ready, overrun}, 32'h1, "buffer full");
      ctrl.set_pins(1'b1, 1'b1);
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
         ctrl.tick(1);
         n++;
      end
      if (n == 100) begin
         miscompares++;
         $display("wrong value at %0t: buffer never drained", $time);
         tally_and_finish();
      end
      ctrl.tick(60);
      ctrl.set_pins(1'b0, 1'b1);
      check(elec, {cur[15:0], 16'hd2e1}, "drained chain");
      check(overrun, 32'h0, "overrun cleared");
      ctrl.set_pins(1'b1, 1'b1);
      $display("test_overrun finished");
   endtask

   initial begin
      ctrl.tick(20);
      rst_b = 1'b1;
      ctrl.tick(2);
      test_reset();
      test_load();
      test_shift();
      test_force();
      test_overrun();
      tally_and_finish();
   end
endmodule
